//--- core/asmb_pkg.sv
// shared constants for the alert source mask bank
package asmb_pkg;
    localparam int CAT_COUNT = 5;
    localparam logic [7:0] CMD_ALERT_MASK = 8'h1b;
    localparam logic [7:0] PHASE_ALL = 8'hff;
    localparam logic [7:0] CAT_OUT_VOLTAGE = 8'h7a;
    localparam logic [7:0] CAT_OUT_CURRENT = 8'h7b;
    localparam logic [7:0] CAT_INPUT = 8'h7c;
    localparam logic [7:0] CAT_TEMPERATURE = 8'h7d;
    localparam logic [7:0] CAT_COMMUNICATION = 8'h7e;
    // bank slots, in category order
    localparam int IDX_OUT_VOLTAGE = 0;
    localparam int IDX_OUT_CURRENT = 1;
    localparam int IDX_INPUT = 2;
    localparam int IDX_TEMPERATURE = 3;
    localparam int IDX_COMMUNICATION = 4;
    // writable positions of each mask byte
    localparam logic [7:0] WR_OUT_VOLTAGE = 8'hfc;
    localparam logic [7:0] WR_OUT_CURRENT = 8'hb0;
    localparam logic [7:0] WR_INPUT = 8'h08;
    localparam logic [7:0] WR_TEMPERATURE = 8'hc0;
    localparam logic [7:0] WR_COMMUNICATION = 8'hf2;
    localparam logic [7:0] WR_TABLE [CAT_COUNT] = '{WR_OUT_VOLTAGE, WR_OUT_CURRENT,
        WR_INPUT, WR_TEMPERATURE, WR_COMMUNICATION};
    // until the image is loaded every source is masked
    localparam logic [7:0] RESET_MASK_BYTE = 8'hff;
    localparam logic [7:0] READ_ZERO = 8'h00;
endpackage

//--- core/asmb_bank.sv
// alert source mask bank: mask bytes, access decode and alert drive
`timescale 1ns/100ps

// Operation
// - writable mask bit zero lets its condition assert alert; one blocks it.
// - output-current mask selected by category byte 7Bh under command 1Bh.
// - input mask selected by category byte 7Ch under command 1Bh.
// - temperature mask selected by category byte 7Dh under command 1Bh.
// - communication mask selected by category byte 7Eh under command 1Bh.
// - output-voltage mask: bits 7:2 writable, bits 1:0 read zero.
// - output-current mask: bits 7,5,4 writable, others read zero.
// - input mask: only bit 3 writable, others read zero.
// - communication mask: bits 7,6,5,4,1 writable, others read zero.
// - masks load from nonvolatile image, back up on change, apply at once.
// - read: category byte written, one mask byte returned.
// - write word: low byte names category, high byte is new mask.
// - output-voltage mask selected by category byte 7Ah under command 1Bh.
// - masking never stops status bits being set; only gates the alert.
module asmb_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic nvm_load,
    input wire logic [39:0] nvm_mask_image,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_command,
    input wire logic [7:0] req_phase,
    input wire logic [7:0] req_category,
    input wire logic [7:0] req_mask,
    input wire logic [39:0] status_flags,
    input wire logic alert_line_in,
    output logic rsp_valid_ff,
    output logic [7:0] rsp_data_ff,
    output logic access_error_ff,
    output logic [39:0] backup_image_ff,
    output logic backup_store_ff,
    output logic alert_line_out_ff,
    output logic alert_line_oe_ff
);
    // ==========================================================
    // access decode
    localparam int N = asmb_pkg::CAT_COUNT;

    // the flat image and status ports hold one mask byte per category slot
    if (N * $bits(mask_ff[0]) != $bits(nvm_mask_image)) begin : g_bad_width
        $error("category count does not match image width");
    end

    logic [7:0] mask_ff [N];
    logic [7:0] nxt_mask [N];
    logic nxt_rsp_valid;
    logic [7:0] nxt_rsp_data;
    logic nxt_access_error;
    logic nxt_backup_store;
    logic nxt_alert_out;
    logic nxt_alert_oe;
    logic [39:0] nxt_backup_image;
    logic hit;
    logic cat_ok;
    int unsigned cat_idx;
    logic [7:0] live [N];

    always_comb begin
        cat_ok = 1'b1;
        cat_idx = 0;
        case (req_category)
            asmb_pkg::CAT_OUT_VOLTAGE: cat_idx = asmb_pkg::IDX_OUT_VOLTAGE;
            asmb_pkg::CAT_OUT_CURRENT: cat_idx = asmb_pkg::IDX_OUT_CURRENT;
            asmb_pkg::CAT_INPUT: cat_idx = asmb_pkg::IDX_INPUT;
            asmb_pkg::CAT_TEMPERATURE: cat_idx = asmb_pkg::IDX_TEMPERATURE;
            asmb_pkg::CAT_COMMUNICATION: cat_idx = asmb_pkg::IDX_COMMUNICATION;
            default: cat_ok = 1'b0;
        endcase
    end

    // only the all-phases selector is served; anything else is refused and flagged
    assign hit = req_valid && (req_command == asmb_pkg::CMD_ALERT_MASK);

    // ==========================================================
    // mask bank
    always_comb begin
        for (int i = 0; i < N; i++) begin
            nxt_mask[i] = mask_ff[i];
            if (nvm_load) begin
                // unsupported positions never store a one
                nxt_mask[i] = nvm_mask_image[i*8 +: 8] & asmb_pkg::WR_TABLE[i];
            end
        end
        nxt_rsp_valid = 1'b0;
        nxt_rsp_data = asmb_pkg::READ_ZERO;
        nxt_access_error = 1'b0;
        nxt_backup_store = 1'b0;
        if (hit && !nvm_load) begin
            if (!cat_ok || req_phase != asmb_pkg::PHASE_ALL) begin
                nxt_access_error = 1'b1;
                nxt_rsp_valid = !req_write;
            end else if (req_write) begin
                // new value takes effect on the very next edge
                nxt_mask[cat_idx] = req_mask & asmb_pkg::WR_TABLE[cat_idx];
                nxt_backup_store = 1'b1;
            end else begin
                nxt_rsp_valid = 1'b1;
                nxt_rsp_data = mask_ff[cat_idx];
            end
        end
        for (int i = 0; i < N; i++) begin
            nxt_backup_image[i*8 +: 8] = nxt_mask[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                mask_ff[i] <= asmb_pkg::RESET_MASK_BYTE & asmb_pkg::WR_TABLE[i];
            end
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= asmb_pkg::READ_ZERO;
            access_error_ff <= 1'b0;
            backup_store_ff <= 1'b0;
            backup_image_ff <= '0;
        end else begin
            mask_ff <= nxt_mask;
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_data_ff <= nxt_rsp_data;
            access_error_ff <= nxt_access_error;
            backup_store_ff <= nxt_backup_store;
            backup_image_ff <= nxt_backup_image;
        end
    end

    // ==========================================================
    // alert drive
    // status flags are only read here, never altered, so a mask cannot hide them
    always_comb begin
        nxt_alert_oe = 1'b0;
        for (int i = 0; i < N; i++) begin
            // a zero mask bit passes its condition; unsupported bits act as masked
            live[i] = status_flags[i*8 +: 8] & ~mask_ff[i] & asmb_pkg::WR_TABLE[i];
            nxt_alert_oe = nxt_alert_oe | (|live[i]);
        end
        nxt_alert_out = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_line_out_ff <= 1'b0;
            alert_line_oe_ff <= 1'b0;
        end else begin
            alert_line_out_ff <= nxt_alert_out;
            alert_line_oe_ff <= nxt_alert_oe;
        end
    end

    // ==========================================================
    // checks
    // flat copy of the bank so that whole-bank stability can be asserted
    logic [39:0] unsup_bits;
    logic [39:0] bank_flat;
    always_comb begin
        for (int i = 0; i < N; i++) begin
            unsup_bits[i*8 +: 8] = mask_ff[i] & ~asmb_pkg::WR_TABLE[i];
            bank_flat[i*8 +: 8] = mask_ff[i];
        end
    end

    a_unsup_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
        unsup_bits == '0) else $error("unsupported mask bit holds a one");

    a_write_takes_effect: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !nvm_load && req_write && cat_ok && req_phase == asmb_pkg::PHASE_ALL
        |=> mask_ff[$past(cat_idx)] == ($past(req_mask) & asmb_pkg::WR_TABLE[$past(cat_idx)])
        && backup_store_ff) else $error("mask write not applied");

    a_current_slot: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !nvm_load && req_write && req_category == asmb_pkg::CAT_OUT_CURRENT
        && req_phase == asmb_pkg::PHASE_ALL
        |=> mask_ff[asmb_pkg::IDX_OUT_CURRENT] == ($past(req_mask) & asmb_pkg::WR_OUT_CURRENT))
        else $error("output current category misrouted");

    a_read_returns_mask: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !nvm_load && !req_write && cat_ok && req_phase == asmb_pkg::PHASE_ALL
        |=> rsp_valid_ff && rsp_data_ff == $past(mask_ff[cat_idx]))
        else $error("read answer wrong");

    a_phase_refused: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !nvm_load && req_phase != asmb_pkg::PHASE_ALL
        |=> access_error_ff && !backup_store_ff && $stable(backup_image_ff))
        else $error("non all-phase access not refused");

    a_nvm_load_image: assert property (@(posedge clk) disable iff (!rst_n)
        nvm_load |=> mask_ff[asmb_pkg::IDX_INPUT] ==
        ($past(nvm_mask_image[15:8]) & asmb_pkg::WR_INPUT)) else $error("nvm load lost");

    a_alert_unmasked: assert property (@(posedge clk) disable iff (!rst_n)
        (status_flags[7:0] & ~mask_ff[asmb_pkg::IDX_OUT_VOLTAGE] & asmb_pkg::WR_OUT_VOLTAGE) != '0
        |=> alert_line_oe_ff && !alert_line_out_ff) else $error("alert not asserted");

    a_alert_masked: assert property (@(posedge clk) disable iff (!rst_n)
        (live[0] | live[1] | live[2] | live[3] | live[4]) == '0 |=> !alert_line_oe_ff)
        else $error("masked source drove alert");

    a_backup_follows: assert property (@(posedge clk) disable iff (!rst_n)
        backup_store_ff |-> backup_image_ff[39:32] == mask_ff[asmb_pkg::IDX_COMMUNICATION])
        else $error("backup image stale");

    // every category byte must land in its own slot and nowhere else
    a_input_slot: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !nvm_load && req_write && req_category == asmb_pkg::CAT_INPUT
        && req_phase == asmb_pkg::PHASE_ALL
        |=> mask_ff[asmb_pkg::IDX_INPUT] == ($past(req_mask) & asmb_pkg::WR_INPUT))
        else $error("input category misrouted");

    a_temp_slot: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !nvm_load && req_write && req_category == asmb_pkg::CAT_TEMPERATURE
        && req_phase == asmb_pkg::PHASE_ALL
        |=> mask_ff[asmb_pkg::IDX_TEMPERATURE] == ($past(req_mask) & asmb_pkg::WR_TEMPERATURE))
        else $error("temperature category misrouted");

    a_comm_slot: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !nvm_load && req_write && req_category == asmb_pkg::CAT_COMMUNICATION
        && req_phase == asmb_pkg::PHASE_ALL
        |=> mask_ff[asmb_pkg::IDX_COMMUNICATION] == ($past(req_mask) & asmb_pkg::WR_COMMUNICATION))
        else $error("communication category misrouted");

    a_voltage_slot: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !nvm_load && req_write && req_category == asmb_pkg::CAT_OUT_VOLTAGE
        && req_phase == asmb_pkg::PHASE_ALL
        |=> mask_ff[asmb_pkg::IDX_OUT_VOLTAGE] == ($past(req_mask) & asmb_pkg::WR_OUT_VOLTAGE))
        else $error("output voltage category misrouted");

    a_current_zero_bits: assert property (@(posedge clk) disable iff (!rst_n)
        (mask_ff[asmb_pkg::IDX_OUT_CURRENT] & ~asmb_pkg::WR_OUT_CURRENT) == 8'h00)
        else $error("current mask holds unsupported one");

    a_input_zero_bits: assert property (@(posedge clk) disable iff (!rst_n)
        (mask_ff[asmb_pkg::IDX_INPUT] & ~asmb_pkg::WR_INPUT) == 8'h00)
        else $error("input mask holds unsupported one");

    a_temp_zero_bits: assert property (@(posedge clk) disable iff (!rst_n)
        (mask_ff[asmb_pkg::IDX_TEMPERATURE] & ~asmb_pkg::WR_TEMPERATURE) == 8'h00)
        else $error("temperature mask holds unsupported one");

    a_comm_zero_bits: assert property (@(posedge clk) disable iff (!rst_n)
        (mask_ff[asmb_pkg::IDX_COMMUNICATION] & ~asmb_pkg::WR_COMMUNICATION) == 8'h00)
        else $error("communication mask holds unsupported one");

    a_refused_bank_kept: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !nvm_load && (!cat_ok || req_phase != asmb_pkg::PHASE_ALL)
        |=> $stable(bank_flat) && !backup_store_ff)
        else $error("refused access changed the bank");

    a_error_source: assert property (@(posedge clk) disable iff (!rst_n)
        access_error_ff
        |-> $past(hit && !nvm_load && (!cat_ok || req_phase != asmb_pkg::PHASE_ALL)))
        else $error("error pulse without refused access");

    // a load wins over a request in the same cycle; the request is dropped with no answer, error or store
    a_load_beats_request: assert property (@(posedge clk) disable iff (!rst_n)
        nvm_load && req_valid
        |=> !rsp_valid_ff && !backup_store_ff && !access_error_ff)
        else $error("request served during load");

    a_store_source: assert property (@(posedge clk) disable iff (!rst_n)
        backup_store_ff
        |-> $past(hit && !nvm_load && req_write && cat_ok && req_phase == asmb_pkg::PHASE_ALL))
        else $error("store pulse without write");

    a_comm_alert: assert property (@(posedge clk) disable iff (!rst_n)
        live[asmb_pkg::IDX_COMMUNICATION] != 8'h00 |=> alert_line_oe_ff)
        else $error("communication source did not alert");

    // open drain: the pad may only ever pull low
    a_alert_out_low: assert property (@(posedge clk) disable iff (!rst_n)
        alert_line_out_ff == 1'b0) else $error("alert pad driven high");

    a_wire_follows: assert property (@(posedge clk) disable iff (!rst_n)
        alert_line_oe_ff |-> !alert_line_in) else $error("alert wire not low");

    a_rsp_source: assert property (@(posedge clk) disable iff (!rst_n)
        rsp_valid_ff |-> $past(hit && !nvm_load && !req_write))
        else $error("answer without read");

    a_idle_data_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !rsp_valid_ff |-> rsp_data_ff == asmb_pkg::READ_ZERO)
        else $error("read data not zero when idle");

    a_read_no_store: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !nvm_load && !req_write |=> !backup_store_ff && $stable(bank_flat))
        else $error("read changed the bank");

    a_write_no_answer: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !nvm_load && req_write |=> !rsp_valid_ff)
        else $error("write produced a read answer");

    // other command codes belong to other blocks and must leave this one untouched
    a_foreign_command: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid && req_command != asmb_pkg::CMD_ALERT_MASK && !nvm_load
        |=> !rsp_valid_ff && !access_error_ff && !backup_store_ff && $stable(bank_flat))
        else $error("foreign command touched the bank");

endmodule

//--- dv/asmb_host_model.sv
// host model: decoded mask transactions and the pulled-up alert wire
`timescale 1ns/100ps
module asmb_host_model (
    input wire logic clk,
    input wire logic oe,
    input wire logic out,
    output logic alert_wire,
    output logic req_valid,
    output logic req_write,
    output logic [7:0] req_command,
    output logic [7:0] req_phase,
    output logic [7:0] req_category,
    output logic [7:0] req_mask
);
    // ==========
    // wire
    // pull-up keeps the wire high unless the device pulls it
    assign alert_wire = oe ? out : 1'b1;
    initial begin
        {req_valid, req_write, req_command, req_phase, req_category, req_mask} = '0;
    end
    // held from launch to the taking edge; answer is read just after that edge
    task automatic xfer(input logic w, input logic [7:0] cat, m, ph);
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_command <= asmb_pkg::CMD_ALERT_MASK;
        req_phase <= ph;
        req_category <= cat;
        req_mask <= m;
        @(posedge clk);
        req_valid <= 1'b0;
        req_mask <= ~m;
        #1;
    endtask
endmodule

//--- dv/alert_source_mask_bank_tb_top.sv
// self-checking bench for the alert source mask bank
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module alert_source_mask_bank_tb_top;
    // ==========
    // harness
    logic clk, rst_n, nvm_load, rsp_valid_ff, access_error_ff, backup_store_ff;
    logic alert_line_out_ff, alert_line_oe_ff, alert_wire, req_valid, req_write;
    logic [7:0] req_command, req_phase, req_category, req_mask, rsp_data_ff;
    logic [39:0] nvm_mask_image, status_flags, backup_image_ff;
    logic [7:0] cats [5] = '{8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e};
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    asmb_bank asmb_bank_i (.clk(clk), .rst_n(rst_n), .nvm_load(nvm_load),
        .nvm_mask_image(nvm_mask_image), .req_valid(req_valid), .req_write(req_write),
        .req_command(req_command), .req_phase(req_phase), .req_category(req_category),
        .req_mask(req_mask), .status_flags(status_flags), .alert_line_in(alert_wire),
        .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff),
        .access_error_ff(access_error_ff), .backup_image_ff(backup_image_ff),
        .backup_store_ff(backup_store_ff), .alert_line_out_ff(alert_line_out_ff),
        .alert_line_oe_ff(alert_line_oe_ff));
    asmb_host_model asmb_host_model_i (.clk(clk), .oe(alert_line_oe_ff),
        .out(alert_line_out_ff), .alert_wire(alert_wire), .req_valid(req_valid),
        .req_write(req_write), .req_command(req_command), .req_phase(req_phase),
        .req_category(req_category), .req_mask(req_mask));
    task automatic rd(input logic [7:0] cat, input logic [7:0] exp);
        asmb_host_model_i.xfer(1'b0, cat, 8'h00, asmb_pkg::PHASE_ALL);
        `CHK(rsp_valid_ff, 1'b1)
        `CHK(rsp_data_ff, exp)
    endtask
    task automatic wr(input logic [7:0] cat, input logic [7:0] m);
        asmb_host_model_i.xfer(1'b1, cat, m, asmb_pkg::PHASE_ALL);
        `CHK(backup_store_ff, 1'b1)
    endtask
    task automatic status_wait(input logic [39:0] s, input logic exp);
        @(posedge clk);
        status_flags <= s;
        repeat (2) @(posedge clk);
        #1;
        `CHK(alert_wire, exp)
    endtask
    task automatic t_masks();
        for (int i = 0; i < 5; i++) begin
            rd(cats[i], asmb_pkg::WR_TABLE[i]);
            wr(cats[i], 8'h00);
            rd(cats[i], 8'h00);
            wr(cats[i], 8'hff);
            rd(cats[i], asmb_pkg::WR_TABLE[i]);
        end
        `CHK(backup_image_ff, 40'hf2c008b0fc)
        $display("test masks done");
    endtask
    task automatic t_nvm();
        @(posedge clk);
        nvm_load <= 1'b1;
        nvm_mask_image <= '0;
        @(posedge clk);
        nvm_load <= 1'b0;
        #1;
        `CHK(backup_store_ff, 1'b0)
        rd(8'h7a, 8'h00);
        $display("test nvm done");
    endtask
    task automatic t_alert();
        wr(8'h7a, 8'hff);
        status_wait(40'h0000000001, 1'b1);
        status_wait(40'h0000000080, 1'b1);
        wr(8'h7a, 8'h7f);
        status_wait(40'h0000000080, 1'b0);
        status_wait(40'h0000000000, 1'b1);
        $display("test alert done");
    endtask
    task automatic t_error();
        asmb_host_model_i.xfer(1'b0, 8'h7f, 8'h00, asmb_pkg::PHASE_ALL);
        `CHK({access_error_ff, rsp_data_ff}, 9'h100)
        asmb_host_model_i.xfer(1'b1, 8'h7b, 8'hff, 8'h00);
        `CHK({access_error_ff, backup_store_ff}, 2'h2)
        rd(8'h7b, 8'h00);
        $display("test error done");
    endtask
    task automatic results();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        {rst_n, nvm_load, nvm_mask_image, status_flags} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_masks();
        t_nvm();
        t_alert();
        t_error();
        results();
    end
endmodule
